//--- hw/pmc_cfg.svh
// constants of the phy management control slice
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_PHY_PORT1     5'h02
`define PMC_PHY_PORT2     5'h03
`define PMC_REG_CTRL      5'h00
`define PMC_REG_STAT      5'h01
`define PMC_REG_IDHI      5'h02
`define PMC_REG_IDLO      5'h03
`define PMC_REG_ADV       5'h04
`define PMC_REG_LPA       5'h05
`define PMC_REG_X1D       5'h1D
`define PMC_REG_X1F       5'h1F
`define PMC_CTRL_RST_VAL  16'h3020
`define PMC_CTRL_WR_MASK  16'h7F3F
`define PMC_B_SOFTRST     15
`define PMC_B_LOOPBACK    14
`define PMC_B_SPEED100    13
`define PMC_B_ANON        12
`define PMC_B_PWRDN       11
`define PMC_B_ISOLATE     10
`define PMC_B_ANRESTART   9
`define PMC_B_DUPLEX      8
`define PMC_B_XALGO       5
`define PMC_B_FORCEMDI    4
`define PMC_B_XOFF        3
`define PMC_B_NOFEF       2
`define PMC_B_NOTX        1
`define PMC_B_NOLED       0
`define PMC_STAT_FIXED    16'h7808
`define PMC_B_ANDONE      5
`define PMC_B_LINKUP      2
`define PMC_ADV_RST_VAL   16'h05E1
`define PMC_ADV_WR_MASK   16'h05E0
`define PMC_LPA_VAL       16'h0001
`define PMC_ID_HI_VAL     16'h1234
`define PMC_ID_LO_VAL     16'h5670
`define PMC_PRE_ONES      6'h20
`define PMC_OP_READ       2'h2
`define PMC_OP_WRITE      2'h1
`define PMC_ADDR_BITS     4'h4
`define PMC_DATA_BITS     4'hF
`endif

//--- hw/pmc_mdio_frame.sv
// serial management frame engine: framing, address capture, read shift-out
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_mdio_frame import pmc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // synchronised link
  input  wire logic        mdcRise,
  input  wire logic        mdioBit,
  output logic             mdioOut,
  output logic             mdioOe,
  // register access
  output logic             reqRead,
  output logic             reqWrite,
  output logic [4:0]       reqPhy,
  output logic [4:0]       reqReg,
  output logic [15:0]      reqData,
  input  wire logic [15:0] rdData
);
  pmc_state_t  state_q;
  logic [5:0]  cnt_q;
  logic [1:0]  op_q;
  logic [1:0]  hitVec;
  logic        hit;

  assign hitVec = pmc_port_hit(reqPhy);
  assign hit    = hitVec[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= PRE;
      cnt_q    <= 6'h00;
      op_q     <= 2'h0;
      reqPhy   <= 5'h00;
      reqReg   <= 5'h00;
      reqData  <= 16'h0000;
      reqRead  <= 1'b0;
      reqWrite <= 1'b0;
      mdioOut  <= 1'b0;
      mdioOe   <= 1'b0;
    end else begin
      reqRead  <= 1'b0;
      reqWrite <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          PRE: begin
            if (mdioBit) begin
              if (cnt_q != `PMC_PRE_ONES) cnt_q <= cnt_q + 6'h01;
            end else if (cnt_q == `PMC_PRE_ONES) begin
              state_q <= START;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          START: begin
            state_q <= mdioBit ? OPC : PRE;
            cnt_q   <= 6'h00;
          end
          OPC: begin
            op_q  <= {op_q[0], mdioBit};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q[0]) begin
              cnt_q   <= 6'h00;
              state_q <= PHYA;
            end
          end
          PHYA: begin
            reqPhy <= {reqPhy[3:0], mdioBit};
            cnt_q  <= cnt_q + 6'h01;
            if (cnt_q[3:0] == `PMC_ADDR_BITS) begin
              cnt_q   <= 6'h00;
              state_q <= ((op_q == `PMC_OP_READ) || (op_q == `PMC_OP_WRITE)) ? REGA : PRE;
            end
          end
          REGA: begin
            reqReg <= {reqReg[3:0], mdioBit};
            cnt_q  <= cnt_q + 6'h01;
            if (cnt_q[3:0] == `PMC_ADDR_BITS) begin
              cnt_q   <= 6'h00;
              state_q <= TURN;
              reqRead <= hit && (op_q == `PMC_OP_READ);
            end
          end
          TURN: begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q[0]) begin
              cnt_q   <= 6'h00;
              state_q <= DATA;
              mdioOut <= rdData[15];
              reqData <= {rdData[14:0], 1'b0};
            end else if (hit && (op_q == `PMC_OP_READ)) begin
              mdioOe  <= 1'b1;
              mdioOut <= 1'b0;
            end
          end
          DATA: begin
            cnt_q <= cnt_q + 6'h01;
            if (op_q == `PMC_OP_READ) begin
              mdioOut <= reqData[15];
              reqData <= {reqData[14:0], 1'b0};
            end else begin
              reqData <= {reqData[14:0], mdioBit};
            end
            if (cnt_q[3:0] == `PMC_DATA_BITS) begin
              cnt_q    <= 6'h00;
              state_q  <= PRE;
              mdioOe   <= 1'b0;
              mdioOut  <= 1'b0;
              reqWrite <= hit && (op_q == `PMC_OP_WRITE);
            end
          end
          default: state_q <= PRE;
        endcase
      end
    end
  end
endmodule : pmc_mdio_frame
`default_nettype wire

//--- hw/pmc_phy_mgmt.sv
// phy management register slice for two copper ports, reached by mdio and spi
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_phy_mgmt import pmc_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // management link pins
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  // decoded spi register access, same clock
  input  wire logic        spiWrite,
  input  wire logic        spiRead,
  input  wire logic        spiPort,
  input  wire logic [4:0]  spiIndex,
  input  wire logic [15:0] spiWrData,
  output logic [15:0]      spiRdData,
  // phy status, same clock
  input  wire logic [1:0]  linkUp,
  input  wire logic [1:0]  anDone,
  // per-port phy controls
  output logic [1:0]       phyReset,
  output logic [1:0]       macLoopback,
  output logic [1:0]       speed100,
  output logic [1:0]       autonegOn,
  output logic [1:0]       powerDown,
  output logic [1:0]       lineIsolate,
  output logic [1:0]       autonegRestart,
  output logic [1:0]       fullDuplex,
  output logic [1:0]       crossoverAlgorithmSelect,
  output logic [1:0]       forceStraightWiring,
  output logic [1:0]       autoCrossoverOff,
  output logic [1:0]       farFaultOff,
  output logic [1:0]       transmitOff,
  output logic [1:0]       linkLedOff
);
  logic        mdcMeta_q;
  logic        mdcSync_q;
  logic        mdcLast_q;
  logic        mdioMeta_q;
  logic        mdioSync_q;
  logic        mdcRise;
  logic        frmRead;
  logic        frmWrite;
  logic [4:0]  frmPhy;
  logic [4:0]  frmReg;
  logic [15:0] frmData;
  logic [15:0] mdioRdData_q;
  logic [15:0] ctrl_q [2];
  logic [15:0] adv_q  [2];
  logic [1:0]  frmHit;
  logic        wrEn   [2];
  logic [4:0]  wrIdx  [2];
  logic [15:0] wrData [2];

  // two-stage synchronisers on the pins; edge found on the second stage only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdcMeta_q  <= 1'b0;
      mdcSync_q  <= 1'b0;
      mdcLast_q  <= 1'b0;
      mdioMeta_q <= 1'b1;
      mdioSync_q <= 1'b1;
    end else begin
      mdcMeta_q  <= mdc;
      mdcSync_q  <= mdcMeta_q;
      mdcLast_q  <= mdcSync_q;
      mdioMeta_q <= mdioIn;
      mdioSync_q <= mdioMeta_q;
    end
  end

  assign mdcRise = mdcSync_q && !mdcLast_q;

  pmc_mdio_frame u_frame (
    .clk      (clk),
    .resetn   (resetn),
    .mdcRise  (mdcRise),
    .mdioBit  (mdioSync_q),
    .mdioOut  (mdioOut),
    .mdioOe   (mdioOe),
    .reqRead  (frmRead),
    .reqWrite (frmWrite),
    .reqPhy   (frmPhy),
    .reqReg   (frmReg),
    .reqData  (frmData),
    .rdData   (mdioRdData_q)
  );

  // only addresses 2 and 3 decode; 1, 4, 5 and 6 upward stay silent
  assign frmHit = pmc_port_hit(frmPhy);

  // read view of one port's register set
  function automatic logic [15:0] reg_view(input logic [4:0] idx, input logic [15:0] ctrl,
                                           input logic [15:0] adv, input logic link, input logic an);
    reg_view = 16'h0000;
    if (idx == `PMC_REG_CTRL) begin
      reg_view = ctrl & `PMC_CTRL_WR_MASK;
    end else if (idx == `PMC_REG_STAT) begin
      reg_view = `PMC_STAT_FIXED;
      reg_view[`PMC_B_ANDONE] = an;
      reg_view[`PMC_B_LINKUP] = link;
    end else if (idx == `PMC_REG_IDHI) begin
      reg_view = `PMC_ID_HI_VAL; // arbitrary identity value
    end else if (idx == `PMC_REG_IDLO) begin
      reg_view = `PMC_ID_LO_VAL; // arbitrary identity value
    end else if (idx == `PMC_REG_ADV) begin
      reg_view = adv;
    end else if (idx == `PMC_REG_LPA) begin
      reg_view = `PMC_LPA_VAL;
    end else if ((idx == `PMC_REG_X1D) || (idx == `PMC_REG_X1F)) begin
      reg_view = 16'h0000;
    end
  endfunction : reg_view

  // read data for the serial engine, captured on the read request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdioRdData_q <= 16'h0000;
    end else if (frmRead) begin
      mdioRdData_q <= reg_view(frmReg, ctrl_q[frmHit[0]], adv_q[frmHit[0]],
                               linkUp[frmHit[0]], anDone[frmHit[0]]);
    end
  end

  // spi read answers one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spiRdData <= 16'h0000;
    end else if (spiRead) begin
      spiRdData <= reg_view(spiIndex, ctrl_q[spiPort], adv_q[spiPort],
                            linkUp[spiPort], anDone[spiPort]);
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      // serial write takes precedence when both paths write the same port in the same cycle
      always_comb begin
        wrEn[p]   = 1'b0;
        wrIdx[p]  = frmReg;
        wrData[p] = frmData;
        if (frmWrite && frmHit[1] && (frmHit[0] == 1'(p))) begin
          wrEn[p] = 1'b1;
        end else if (spiWrite && (spiPort == 1'(p))) begin
          wrEn[p]   = 1'b1;
          wrIdx[p]  = spiIndex;
          wrData[p] = spiWrData;
        end
      end

      // control register; a reset write reloads defaults, bit 15 never stored
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          ctrl_q[p] <= `PMC_CTRL_RST_VAL;
        end else if (wrEn[p] && (wrIdx[p] == `PMC_REG_CTRL)) begin
          if (wrData[p][`PMC_B_SOFTRST]) begin
            ctrl_q[p] <= `PMC_CTRL_RST_VAL;
          end else begin
            ctrl_q[p] <= wrData[p] & `PMC_CTRL_WR_MASK;
          end
        end
      end

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          adv_q[p] <= `PMC_ADV_RST_VAL;
        end else if (wrEn[p] && (wrIdx[p] == `PMC_REG_ADV)) begin
          adv_q[p] <= (wrData[p] & `PMC_ADV_WR_MASK) | (`PMC_ADV_RST_VAL & ~`PMC_ADV_WR_MASK);
        end
      end

      // one-cycle action pulses
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          phyReset[p]       <= 1'b0;
          autonegRestart[p] <= 1'b0;
        end else begin
          phyReset[p]       <= wrEn[p] && (wrIdx[p] == `PMC_REG_CTRL)
                               && wrData[p][`PMC_B_SOFTRST];
          autonegRestart[p] <= wrEn[p] && (wrIdx[p] == `PMC_REG_CTRL)
                               && !wrData[p][`PMC_B_SOFTRST]
                               && wrData[p][`PMC_B_ANRESTART];
        end
      end

      // level controls registered from the control word
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          macLoopback[p]              <= 1'b0;
          speed100[p]                 <= 1'b1;
          autonegOn[p]                <= 1'b1;
          powerDown[p]                <= 1'b0;
          lineIsolate[p]              <= 1'b0;
          fullDuplex[p]               <= 1'b0;
          crossoverAlgorithmSelect[p] <= 1'b1;
          forceStraightWiring[p]      <= 1'b0;
          autoCrossoverOff[p]         <= 1'b0;
          farFaultOff[p]              <= 1'b0;
          transmitOff[p]              <= 1'b0;
          linkLedOff[p]               <= 1'b0;
        end else begin
          macLoopback[p]              <= ctrl_q[p][`PMC_B_LOOPBACK];
          speed100[p]                 <= ctrl_q[p][`PMC_B_SPEED100];
          autonegOn[p]                <= ctrl_q[p][`PMC_B_ANON];
          powerDown[p]                <= ctrl_q[p][`PMC_B_PWRDN];
          lineIsolate[p]              <= ctrl_q[p][`PMC_B_ISOLATE];
          fullDuplex[p]               <= ctrl_q[p][`PMC_B_DUPLEX];
          crossoverAlgorithmSelect[p] <= ctrl_q[p][`PMC_B_XALGO];
          // forced wiring only matters while auto crossover is off
          forceStraightWiring[p]      <= ctrl_q[p][`PMC_B_XOFF] && ctrl_q[p][`PMC_B_FORCEMDI];
          autoCrossoverOff[p]         <= ctrl_q[p][`PMC_B_XOFF];
          farFaultOff[p]              <= ctrl_q[p][`PMC_B_NOFEF];
          transmitOff[p]              <= ctrl_q[p][`PMC_B_NOTX];
          linkLedOff[p]               <= ctrl_q[p][`PMC_B_NOLED];
        end
      end
    end
  endgenerate
endmodule : pmc_phy_mgmt
`default_nettype wire

//--- hw/pmc_pkg.sv
// types and decode helpers of the phy management control slice
`default_nettype none
`include "pmc_cfg.svh"
package pmc_pkg;
  typedef enum logic [2:0] {PRE, START, OPC, PHYA, REGA, TURN, DATA} pmc_state_t;

  // hit flag and port number for a phy address
  function automatic logic [1:0] pmc_port_hit(input logic [4:0] phy);
    pmc_port_hit = 2'h0;
    if (phy == `PMC_PHY_PORT1) begin
      pmc_port_hit = 2'h2;
    end else if (phy == `PMC_PHY_PORT2) begin
      pmc_port_hit = 2'h3;
    end
  endfunction : pmc_port_hit
endpackage : pmc_pkg
`default_nettype wire

//--- testbench/pmc_mdio_host.sv
// station management host model: drives mdc and mdio frames on a pulled-up wire
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_mdio_host (
  // clock
  input  wire logic clk,
  // link
  output logic      mdc,
  output logic      mdioIn,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  // observation
  output logic      sawOe
);
  logic hostOe;
  logic hostBit;
  // released wire floats to the pull-up level
  assign mdioIn = hostOe ? hostBit : (mdioOe ? mdioOut : 1'b1);
  initial begin
    mdc = 1'b0;
    hostOe = 1'b1;
    hostBit = 1'b1;
    sawOe = 1'b0;
  end
  always @(posedge clk) begin
    if (mdioOe) begin
      sawOe <= 1'b1;
    end
  end
  // one slow mdc period; the sample is taken just before the rise
  task automatic cyc(input logic b, output logic s);
    hostBit <= b;
    repeat (5) @(posedge clk);
    s = mdioIn;
    mdc <= 1'b1;
    repeat (5) @(posedge clk);
    mdc <= 1'b0;
  endtask : cyc
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [15:0] hdr;
    logic        s;
    sawOe = 1'b0;
    hdr = {2'h1, rd ? `PMC_OP_READ : `PMC_OP_WRITE, phy, ra, 2'h2};
    for (int i = 0; i < 32; i++) begin
      cyc(1'b1, s);
    end
    for (int i = 15; i >= 0; i--) begin
      // host lets go of the wire for the read turnaround
      if (rd && i < 2) begin
        hostOe <= 1'b0;
      end
      cyc(hdr[i], s);
    end
    for (int i = 15; i >= 0; i--) begin
      cyc(wd[i], s);
      q[i] = s;
    end
    // idle level goes back well before the next frame can drive the bit again
    hostBit <= 1'b1;
    repeat (8) @(posedge clk);
    hostOe <= 1'b1;
  endtask : frame
endmodule : pmc_mdio_host
`default_nettype wire

//--- testbench/pmc_phy_mgmt_assertions.sv
// port-level checker of the phy management slice
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_phy_mgmt_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // spi access and status
  input wire logic        spiWrite,
  input wire logic        spiRead,
  input wire logic        spiPort,
  input wire logic [4:0]  spiIndex,
  input wire logic [15:0] spiWrData,
  input wire logic [15:0] spiRdData,
  input wire logic [1:0]  linkUp,
  input wire logic [1:0]  anDone,
  // controls
  input wire logic [1:0]  phyReset,
  input wire logic [1:0]  autonegRestart,
  input wire logic [1:0]  fullDuplex,
  input wire logic [1:0]  macLoopback,
  input wire logic [1:0]  speed100,
  input wire logic [1:0]  autonegOn,
  input wire logic [1:0]  crossoverAlgorithmSelect,
  input wire logic [1:0]  forceStraightWiring,
  input wire logic [1:0]  autoCrossoverOff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        wr0;
  logic [15:0] stExp;
  assign wr0 = spiWrite && spiIndex == `PMC_REG_CTRL;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stExp <= 16'h0000;
    end else begin
      stExp <= `PMC_STAT_FIXED | {10'h000, anDone[spiPort], 2'h0, linkUp[spiPort], 2'h0};
    end
  end
  a_softrst_pulse: assert property (wr0 && spiWrData[15] |=> phyReset[$past(spiPort)])
    else $error("soft reset pulse missing");
  a_softrst_dflt: assert property (wr0 && spiWrData[15] |=> ##1 speed100[$past(spiPort, 2)] &&
    autonegOn[$past(spiPort, 2)] && !fullDuplex[$past(spiPort, 2)]) else $error("soft reset defaults wrong");
  a_restart_pulse: assert property (wr0 && !spiWrData[15] && spiWrData[9] |=> autonegRestart[$past(spiPort)])
    else $error("restart pulse missing");
  a_duplex_follow: assert property (wr0 && !spiWrData[15] |=> ##1
    fullDuplex[$past(spiPort, 2)] == $past(spiWrData[8], 2)) else $error("duplex control wrong");
  a_loop_follow: assert property (wr0 && !spiWrData[15] |=> ##1
    macLoopback[$past(spiPort, 2)] == $past(spiWrData[14], 2)) else $error("loopback control wrong");
  a_straight_wire: assert property (wr0 && !spiWrData[15] |=> ##1
    forceStraightWiring[$past(spiPort, 2)] == ($past(spiWrData[4], 2) && $past(spiWrData[3], 2)) &&
    autoCrossoverOff[$past(spiPort, 2)] == $past(spiWrData[3], 2)) else $error("crossover control wrong");
  a_unmapped_zero: assert property (spiRead && spiIndex inside {[5'h06:5'h1F]} |=> spiRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_status_read: assert property (spiRead && spiIndex == `PMC_REG_STAT |=> spiRdData == stExp)
    else $error("status read wrong");
  a_rd_hold: assert property (!spiRead |=> $stable(spiRdData))
    else $error("read data moved");
  a_bits76_zero: assert property (spiRead && spiIndex == `PMC_REG_CTRL |=> spiRdData[7:6] == 2'h0)
    else $error("control bits 7 6 not zero");
  a_reset_vals: assert property ($rose(resetn) |-> speed100 == 2'h3 && autonegOn == 2'h3 &&
    crossoverAlgorithmSelect == 2'h3 && fullDuplex == 2'h0 && phyReset == 2'h0) else $error("reset values wrong");
endmodule : pmc_phy_mgmt_assertions
bind pmc_phy_mgmt pmc_phy_mgmt_assertions u_chk (.clk, .resetn, .spiWrite, .spiRead, .spiPort, .spiIndex,
  .spiWrData, .spiRdData, .linkUp, .anDone, .phyReset, .autonegRestart, .fullDuplex, .macLoopback, .speed100,
  .autonegOn, .crossoverAlgorithmSelect, .forceStraightWiring, .autoCrossoverOff);
`default_nettype wire

//--- testbench/pmc_phy_mgmt_tb.sv
// self-checking bench of the phy management slice
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_phy_mgmt_tb;
  logic clk, resetn, spiWrite, spiRead, spiPort, mdc, mdioIn, mdioOut, mdioOe, sawOe, p;
  logic [4:0] spiIndex;
  logic [15:0] spiWrData, spiRdData, d, q;
  logic [15:0] ctl [2];
  logic [1:0] linkUp, anDone, phyReset, macLoopback, speed100, autonegOn, powerDown, lineIsolate, autonegRestart;
  logic [1:0] fullDuplex, crossoverAlgorithmSelect, forceStraightWiring, autoCrossoverOff, farFaultOff;
  logic [1:0] transmitOff, linkLedOff;
  int bad_count, n_tests, seed;
  pmc_phy_mgmt u_dut (.clk, .resetn, .mdc, .mdioIn, .mdioOut, .mdioOe, .spiWrite, .spiRead, .spiPort, .spiIndex,
    .spiWrData, .spiRdData, .linkUp, .anDone, .phyReset, .macLoopback, .speed100, .autonegOn, .powerDown,
    .lineIsolate, .autonegRestart, .fullDuplex, .crossoverAlgorithmSelect, .forceStraightWiring,
    .autoCrossoverOff, .farFaultOff, .transmitOff, .linkLedOff);
  pmc_mdio_host u_host (.clk, .mdc, .mdioIn, .mdioOut, .mdioOe, .sawOe);
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic spi(input logic wr, input logic pt, input logic [4:0] idx, input logic [15:0] wd);
    spiWrite <= wr;
    spiRead <= !wr;
    spiPort <= pt;
    spiIndex <= idx;
    spiWrData <= wd;
    @(posedge clk);
    spiWrite <= 1'b0;
    spiRead <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : spi
  function automatic logic [15:0] nx(input logic [15:0] w);
    nx = w[15] ? `PMC_CTRL_RST_VAL : w & `PMC_CTRL_WR_MASK;
  endfunction : nx
  function automatic logic [15:0] ex(input logic [15:0] r);
    ex = {4'h0, r[14:10], r[8], r[5], r[4] & r[3], r[3:0]};
  endfunction : ex
  function automatic logic [15:0] lvl(input logic pt);
    lvl = {4'h0, macLoopback[pt], speed100[pt], autonegOn[pt], powerDown[pt], lineIsolate[pt], fullDuplex[pt],
      crossoverAlgorithmSelect[pt], forceStraightWiring[pt], autoCrossoverOff[pt], farFaultOff[pt],
      transmitOff[pt], linkLedOff[pt]};
  endfunction : lvl
  function automatic logic [15:0] rdExp(input int i, input logic pt);
    case (i)
      1: rdExp = `PMC_STAT_FIXED | {10'h000, anDone[pt], 2'h0, linkUp[pt], 2'h0};
      2: rdExp = `PMC_ID_HI_VAL;
      3: rdExp = `PMC_ID_LO_VAL;
      4: rdExp = `PMC_ADV_RST_VAL;
      5: rdExp = `PMC_LPA_VAL;
      default: rdExp = 16'h0000;
    endcase
  endfunction : rdExp
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {spiWrite, spiRead, spiPort, spiIndex, spiWrData, linkUp, anDone} = '0;
    seed = 13368;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      ctl[i] = `PMC_CTRL_RST_VAL;
      chk(lvl(i[0]), ex(ctl[i]));
      spi(1'b0, i[0], `PMC_REG_CTRL, 16'h0000);
      chk(spiRdData, ctl[i]);
    end
    // corner patterns first, then random control words
    for (int i = 0; i < 44; i++) begin
      p = $random(seed);
      d = $random(seed);
      d[15] = d[2:0] == 3'h0;
      if (i < 4) begin
        d = i[1] ? (i[0] ? 16'h8000 : 16'h7FFF) : (i[0] ? 16'h0000 : 16'hFFFF);
      end
      spi(1'b1, p, `PMC_REG_CTRL, d);
      ctl[p] = nx(d);
      chk(lvl(p), ex(ctl[p]));
      chk(lvl(!p), ex(ctl[!p]));
      spi(1'b0, p, `PMC_REG_CTRL, 16'h0000);
      chk(spiRdData, ctl[p]);
    end
    for (int i = 1; i < 32; i++) begin
      p = $random(seed);
      linkUp <= $random(seed);
      anDone <= $random(seed);
      if (i != 4) begin
        spi(1'b1, p, i[4:0], 16'hFFFF);
      end
      spi(1'b0, p, i[4:0], 16'h0000);
      chk(spiRdData, rdExp(i, p));
    end
    u_host.frame(1'b0, `PMC_PHY_PORT1, `PMC_REG_CTRL, 16'h0100, q);
    ctl[0] = nx(16'h0100);
    spi(1'b0, 1'b0, `PMC_REG_CTRL, 16'h0000);
    chk(spiRdData, ctl[0]);
    u_host.frame(1'b0, `PMC_PHY_PORT2, `PMC_REG_CTRL, 16'h8000, q);
    ctl[1] = `PMC_CTRL_RST_VAL;
    u_host.frame(1'b1, `PMC_PHY_PORT2, `PMC_REG_CTRL, 16'hFFFF, q);
    chk(q, ctl[1]);
    // reserved addresses and an external transceiver address are never answered
    for (int i = 0; i < 4; i++) begin
      d[4:0] = i == 3 ? 5'h06 : (i == 0 ? 5'h01 : i[4:0] + 5'h03);
      u_host.frame(1'b0, d[4:0], `PMC_REG_CTRL, 16'h7FFF, q);
      u_host.frame(1'b1, d[4:0], `PMC_REG_CTRL, 16'hFFFF, q);
      chk({15'h0000, sawOe}, 16'h0000);
    end
    for (int i = 0; i < 2; i++) begin
      spi(1'b0, i[0], `PMC_REG_CTRL, 16'h0000);
      chk(spiRdData, ctl[i]);
    end
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : pmc_phy_mgmt_tb
`default_nettype wire
